// *** rtl/dpc_counter.sv ***
// drive pulse counter: terminal functions, 16-bit accumulator, count outputs
// assumes a classic wishbone master on clk_i; pins arrive synchronous-ish
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module dpc_counter (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // wishbone slave
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [dpc_pkg::ADR_W-1:0]  adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  // input terminals
  input  wire logic                       general_input_one_i,
  input  wire logic                       general_input_two_i,
  input  wire logic                       general_input_three_i,
  input  wire logic                       general_input_four_i,
  input  wire logic                       fast_pulse_input_i,
  // output terminals
  output logic                            transistor_output_o,
  output logic                            relay_output_first_o,
  output logic                            relay_output_second_o,
  // interrupt
  output logic                            irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  dpc_pkg::dpc_cfg_type                 cfg;
  dpc_pkg::dpc_cfg_type                 next_cfg;
  logic [dpc_pkg::CNT_W-1:0]            count_accumulator;
  logic [dpc_pkg::CNT_W-1:0]            next_count;
  logic [dpc_pkg::IRQ_W-1:0]            irq_status;
  logic [dpc_pkg::IRQ_W-1:0]            irq_mask;
  logic [dpc_pkg::IRQ_W-1:0]            irq_event;
  logic [dpc_pkg::NUM_OUT-1:0]          out_q;
  logic [dpc_pkg::NUM_OUT-1:0]          next_out;
  logic                                 ack;
  logic [31:0]                          rdata;
  logic                                 set_hit_q;
  logic                                 desig_hit_q;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [dpc_pkg::CNT_W-1:0] lane_merge16(
    input logic [dpc_pkg::CNT_W-1:0] old,
    input logic [31:0]               wdat,
    input logic [3:0]                sel
  );
    lane_merge16 = old;
    if (sel[0]) begin
      lane_merge16[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      lane_merge16[15:8] = wdat[15:8];
    end
  endfunction : lane_merge16

  function automatic logic out_level(
    input logic [dpc_pkg::OCODE_W-1:0] code,
    input logic                        set_hit,
    input logic                        desig_hit
  );
    // other codes belong to drive functions outside this block: held off
    if (code == dpc_pkg::OUT_CODE_SET) begin
      out_level = set_hit;
    end else if (code == dpc_pkg::OUT_CODE_DES) begin
      out_level = desig_hit;
    end else begin
      out_level = 1'b0;
    end
  endfunction : out_level

  ////////////////////////////////////////////////////////////////////////////////
  // input terminals

  wire logic [dpc_pkg::NUM_IN-1:0] in_level;
  wire logic [dpc_pkg::NUM_IN-1:0] in_rise;
  wire logic [dpc_pkg::NUM_IN-1:0] in_enable;
  wire logic [dpc_pkg::NUM_IN-1:0] is_trig;
  wire logic [dpc_pkg::NUM_IN-1:0] is_clear;

  dpc_input_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   ({fast_pulse_input_i, general_input_four_i, general_input_three_i,
               general_input_two_i, general_input_one_i}),
    .level_o (in_level),
    .rise_o  (in_rise)
  );

  // fast input takes part only as a digital input; in pulse mode this block
  // ignores its edges and levels, so software must switch its type first
  assign in_enable = {cfg.fast_type == dpc_pkg::FAST_IS_DIGITAL,
                      {(dpc_pkg::NUM_IN-1){1'b1}}};

  for (genvar i = 0; i < dpc_pkg::NUM_IN; i++) begin : g_func
    assign is_trig[i]  = cfg.in_func[i] == dpc_pkg::IN_CODE_TRIG;
    assign is_clear[i] = cfg.in_func[i] == dpc_pkg::IN_CODE_CLEAR;
  end

  wire logic trig_hit  = |(in_rise & in_enable & is_trig);
  wire logic clear_hit = |(in_level & in_enable & is_clear);

  ////////////////////////////////////////////////////////////////////////////////
  // accumulator

  wire logic at_set    = count_accumulator >= cfg.set_value;
  wire logic set_hit   = count_accumulator == cfg.set_value;
  wire logic desig_hit = count_accumulator == cfg.desig_value;
  wire logic wrap      = trig_hit && !clear_hit && at_set;

  // clear outranks a pulse in the same cycle; several pulses together add one
  always_comb begin
    next_count = count_accumulator;
    if (clear_hit) begin
      next_count = dpc_pkg::CNT_ZERO;
    end else if (trig_hit) begin
      if (at_set) begin
        next_count = dpc_pkg::CNT_ZERO;
      end else begin
        next_count = count_accumulator + dpc_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_accumulator <= dpc_pkg::CNT_ZERO;
    end else begin
      count_accumulator <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output terminals

  always_comb begin
    for (int j = 0; j < dpc_pkg::NUM_OUT; j++) begin
      next_out[j] = out_level(cfg.out_func[j], set_hit, desig_hit);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= '0;
    end else begin
      out_q <= next_out;
    end
  end

  assign transistor_output_o   = out_q[0];
  assign relay_output_first_o  = out_q[1];
  assign relay_output_second_o = out_q[2];

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  wire logic [dpc_pkg::ADR_W-1:0] word = {adr_i[dpc_pkg::ADR_W-1:2], 2'b00};
  wire logic req      = cyc_i && stb_i;
  wire logic take     = req && !ack;
  wire logic wr_en    = req && ack && we_i;
  wire logic rd_done  = req && ack && !we_i;
  wire logic rd_stat  = rd_done && word == dpc_pkg::OFS_IRQ_STATUS;
  wire logic wr_lane0 = wr_en && sel_i[0];

  wire logic [dpc_pkg::CNT_W-1:0] set_wr   = lane_merge16(cfg.set_value, dat_i, sel_i);
  wire logic [dpc_pkg::CNT_W-1:0] desig_wr = lane_merge16(cfg.desig_value, dat_i, sel_i);
  wire logic [dpc_pkg::CODE_W-1:0] code_wr = dat_i[dpc_pkg::CODE_W-1:0];
  wire logic code_ok = code_wr <= dpc_pkg::IN_CODE_MAX;

  ////////////////////////////////////////////////////////////////////////////////
  // register writes; out of range values are dropped and the old one kept

  always_comb begin
    next_cfg = cfg;
    if (wr_lane0 && word == dpc_pkg::OFS_FAST_TYPE) begin
      next_cfg.fast_type = dat_i[0];
    end
    if (wr_lane0 && code_ok) begin
      case (word)
        dpc_pkg::OFS_IN1_FUNC:  next_cfg.in_func[0] = code_wr;
        dpc_pkg::OFS_IN2_FUNC:  next_cfg.in_func[1] = code_wr;
        dpc_pkg::OFS_IN3_FUNC:  next_cfg.in_func[2] = code_wr;
        dpc_pkg::OFS_IN4_FUNC:  next_cfg.in_func[3] = code_wr;
        dpc_pkg::OFS_FAST_FUNC: next_cfg.in_func[dpc_pkg::FAST_IDX] = code_wr;
        default:                next_cfg.fast_type = next_cfg.fast_type;
      endcase
    end
    if (wr_lane0) begin
      case (word)
        dpc_pkg::OFS_TRAN_FUNC: next_cfg.out_func[0] = dat_i[dpc_pkg::OCODE_W-1:0];
        dpc_pkg::OFS_REL1_FUNC: next_cfg.out_func[1] = dat_i[dpc_pkg::OCODE_W-1:0];
        dpc_pkg::OFS_REL2_FUNC: next_cfg.out_func[2] = dat_i[dpc_pkg::OCODE_W-1:0];
        default:                next_cfg.fast_type = next_cfg.fast_type;
      endcase
    end
    if (wr_en && word == dpc_pkg::OFS_SET_VALUE && set_wr >= cfg.desig_value) begin
      next_cfg.set_value = set_wr;
    end
    if (wr_en && word == dpc_pkg::OFS_DESIG_VAL && desig_wr <= cfg.set_value) begin
      next_cfg.desig_value = desig_wr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= dpc_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign irq_event[dpc_pkg::IRQ_SET]   = set_hit && !set_hit_q;
  assign irq_event[dpc_pkg::IRQ_DESIG] = desig_hit && !desig_hit_q;
  assign irq_event[dpc_pkg::IRQ_WRAP]  = wrap;

  wire logic [dpc_pkg::IRQ_W-1:0] read_bits =
    rd_stat ? dat_o[dpc_pkg::IRQ_W-1:0] : '0;

  // only bits shown to software are cleared; a new event still sets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status  <= '0;
      irq_mask    <= '0;
      set_hit_q   <= 1'b1;
      desig_hit_q <= 1'b1;
    end else begin
      irq_status  <= (irq_status & ~read_bits) | irq_event;
      set_hit_q   <= set_hit;
      desig_hit_q <= desig_hit;
      if (wr_lane0 && word == dpc_pkg::OFS_IRQ_MASK) begin
        irq_mask <= dat_i[dpc_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge

  always_comb begin
    rdata = '0;
    case (word)
      dpc_pkg::OFS_FAST_TYPE:  rdata[0] = cfg.fast_type;
      dpc_pkg::OFS_IN1_FUNC:   rdata[dpc_pkg::CODE_W-1:0] = cfg.in_func[0];
      dpc_pkg::OFS_IN2_FUNC:   rdata[dpc_pkg::CODE_W-1:0] = cfg.in_func[1];
      dpc_pkg::OFS_IN3_FUNC:   rdata[dpc_pkg::CODE_W-1:0] = cfg.in_func[2];
      dpc_pkg::OFS_IN4_FUNC:   rdata[dpc_pkg::CODE_W-1:0] = cfg.in_func[3];
      dpc_pkg::OFS_FAST_FUNC:  rdata[dpc_pkg::CODE_W-1:0] = cfg.in_func[dpc_pkg::FAST_IDX];
      dpc_pkg::OFS_TRAN_FUNC:  rdata[dpc_pkg::OCODE_W-1:0] = cfg.out_func[0];
      dpc_pkg::OFS_REL1_FUNC:  rdata[dpc_pkg::OCODE_W-1:0] = cfg.out_func[1];
      dpc_pkg::OFS_REL2_FUNC:  rdata[dpc_pkg::OCODE_W-1:0] = cfg.out_func[2];
      dpc_pkg::OFS_SET_VALUE:  rdata[dpc_pkg::CNT_W-1:0] = cfg.set_value;
      dpc_pkg::OFS_DESIG_VAL:  rdata[dpc_pkg::CNT_W-1:0] = cfg.desig_value;
      dpc_pkg::OFS_ACCUM:      rdata[dpc_pkg::CNT_W-1:0] = count_accumulator;
      dpc_pkg::OFS_IRQ_STATUS: rdata[dpc_pkg::IRQ_W-1:0] = irq_status;
      dpc_pkg::OFS_IRQ_MASK:   rdata[dpc_pkg::IRQ_W-1:0] = irq_mask;
      dpc_pkg::OFS_PIN_STATE: begin
        rdata[dpc_pkg::NUM_IN-1:0] = in_level;
        rdata[dpc_pkg::PIN_OUT_LSB +: dpc_pkg::NUM_OUT] = out_q;
      end
      default:                 rdata = '0;
    endcase
  end

  // one wait cycle: data is captured when the request is first seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      dat_o <= '0;
    end else begin
      ack <= take;
      if (take) begin
        dat_o <= rdata;
      end
    end
  end

  assign ack_o = ack;

endmodule : dpc_counter

// *** rtl/dpc_input_sync.sv ***
// synchroniser and rising edge finder for the input terminals
// assumes terminal levels are already clean of contact bounce
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module dpc_input_sync (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // terminals
  input  wire logic [dpc_pkg::NUM_IN-1:0] raw_i,
  output logic      [dpc_pkg::NUM_IN-1:0] level_o,
  output logic      [dpc_pkg::NUM_IN-1:0] rise_o
);

  logic [dpc_pkg::NUM_IN-1:0] meta;
  logic [dpc_pkg::NUM_IN-1:0] stable;
  logic [dpc_pkg::NUM_IN-1:0] prev;

  // meta feeds only stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= '0;
      stable <= '0;
      prev   <= '0;
    end else begin
      meta   <= raw_i;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~prev;

endmodule : dpc_input_sync

// *** rtl/dpc_pkg.sv ***
// constants and types shared by the drive pulse counter
// assumes a 32-bit classic wishbone bus with byte addresses
package dpc_pkg;

  localparam int unsigned CODE_W  = 7;
  localparam int unsigned OCODE_W = 6;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned NUM_IN  = 5;
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned IRQ_W   = 3;
  localparam int unsigned ADR_W   = 6;

  // terminal index of the fast input inside the input vector
  localparam int unsigned FAST_IDX = 4;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_FAST_TYPE  = 6'h00;
  localparam logic [ADR_W-1:0] OFS_IN1_FUNC   = 6'h04;
  localparam logic [ADR_W-1:0] OFS_IN2_FUNC   = 6'h08;
  localparam logic [ADR_W-1:0] OFS_IN3_FUNC   = 6'h0C;
  localparam logic [ADR_W-1:0] OFS_IN4_FUNC   = 6'h10;
  localparam logic [ADR_W-1:0] OFS_FAST_FUNC  = 6'h14;
  localparam logic [ADR_W-1:0] OFS_TRAN_FUNC  = 6'h18;
  localparam logic [ADR_W-1:0] OFS_REL1_FUNC  = 6'h1C;
  localparam logic [ADR_W-1:0] OFS_REL2_FUNC  = 6'h20;
  localparam logic [ADR_W-1:0] OFS_SET_VALUE  = 6'h24;
  localparam logic [ADR_W-1:0] OFS_DESIG_VAL  = 6'h28;
  localparam logic [ADR_W-1:0] OFS_ACCUM      = 6'h2C;
  localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 6'h30;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK   = 6'h34;
  localparam logic [ADR_W-1:0] OFS_PIN_STATE  = 6'h38;

  // field positions in the pin state register
  localparam int unsigned PIN_OUT_LSB = 8;

  // interrupt status bits
  localparam int unsigned IRQ_SET   = 0;
  localparam int unsigned IRQ_DESIG = 1;
  localparam int unsigned IRQ_WRAP  = 2;

  // terminal function codes
  localparam logic [CODE_W-1:0]  IN_CODE_CLEAR = 7'h1C;
  localparam logic [CODE_W-1:0]  IN_CODE_TRIG  = 7'h1F;
  localparam logic [CODE_W-1:0]  IN_CODE_MAX   = 7'h5F;
  localparam logic [OCODE_W-1:0] OUT_CODE_SET  = 6'h12;
  localparam logic [OCODE_W-1:0] OUT_CODE_DES  = 6'h13;

  // fast input type: pulse input or ordinary digital input
  localparam logic FAST_IS_PULSE   = 1'b0;
  localparam logic FAST_IS_DIGITAL = 1'b1;

  typedef struct packed {
    logic                            fast_type;
    logic [NUM_IN-1:0][CODE_W-1:0]   in_func;
    logic [NUM_OUT-1:0][OCODE_W-1:0] out_func;
    logic [CNT_W-1:0]                set_value;
    logic [CNT_W-1:0]                desig_value;
  } dpc_cfg_type;

  // in_func order: fast, four, three, two, one; out_func: relay2, relay1, transistor
  localparam dpc_cfg_type CFG_RESET = '{
    fast_type:   FAST_IS_PULSE,
    in_func:     {7'h00, 7'h00, 7'h07, 7'h04, 7'h01},
    out_func:    {6'h05, 6'h01, 6'h00},
    set_value:   16'h0000,
    desig_value: 16'h0000
  };

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

endpackage : dpc_pkg

// *** test/dpc_counter_props.sv ***
// port checker for the pulse counter: bus handshake, reset, pins, irq
// assumes binding onto dpc_counter; reset synchronous and active high
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module dpc_chk (
  // clock and reset
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  // wishbone
  input wire logic                      cyc_i,
  input wire logic                      stb_i,
  input wire logic                      we_i,
  input wire logic [dpc_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0]               dat_o,
  input wire logic                      ack_o,
  // output terminals and interrupt
  input wire logic                      transistor_output_o,
  input wire logic                      relay_output_first_o,
  input wire logic                      relay_output_second_o,
  input wire logic                      irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       req;
  logic [2:0] pins;
  assign req = cyc_i && stb_i && !ack_o;
  assign pins = {relay_output_second_o, relay_output_first_o, transistor_output_o};
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (req |=> ack_o)
    else $error("request not answered in the next cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  unmapped_zero_a: assert property (ack_o && !we_i && adr_i[5:2] == 4'hF |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  data_hold_a: assert property (!req |=> $stable(dat_o))
    else $error("read data moved without a request");
  reset_quiet_a: assert property ($past(rst_i) |-> !ack_o && !irq_o && pins == 3'h0)
    else $error("outputs not quiet after reset");
  pin_mirror_a: assert property (ack_o && !we_i && adr_i == dpc_pkg::OFS_PIN_STATE
    |-> dat_o[dpc_pkg::PIN_OUT_LSB +: 3] == $past(pins))
    else $error("pin state read differs from output pins");
  irq_sticky_a: assert property (irq_o && !ack_o |=> irq_o)
    else $error("interrupt dropped without a bus access");
  irq_seen_c: cover property ($rose(irq_o));
  set_hit_c: cover property ($rose(transistor_output_o));
  desig_hit_c: cover property ($rose(relay_output_first_o));
endmodule : dpc_chk

bind dpc_counter dpc_chk i_chk (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
  .transistor_output_o, .relay_output_first_o, .relay_output_second_o, .irq_o
);

// *** test/dpc_pulse_src.sv ***
// pulse source standing in for a photoelectric switch on the terminals
// assumes one request at a time; an idle switch leaves its pins low
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module dpc_pulse_src #(
  parameter int HI = 2,
  parameter int LO = 3
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request
  input  wire logic       go_i,
  input  wire logic [4:0] fire_i,
  // terminals
  output logic      [4:0] pins_o
);
  logic [7:0] left;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left   <= 8'h00;
      pins_o <= 5'h00;
    end else if (left == 8'h00 && go_i) begin
      left   <= 8'(HI + LO);
      pins_o <= fire_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
      // low gap keeps pulses apart for the edge finder
      if (left == 8'(LO + 1)) pins_o <= 5'h00;
    end
  end
endmodule : dpc_pulse_src

// *** test/tb_top.sv ***
// self-checking bench for the drive pulse counter
// assumes dpc_counter, the pulse source and the bound checker are compiled
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  typedef struct packed {
    logic [5:0]  ofs;
    logic [4:0]  pin;
    logic [31:0] cnt;
  } dpc_row_type;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, go, irq_o;
  logic transistor_output_o, relay_output_first_o, relay_output_second_o;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i;
  logic [4:0]  fire, pins;
  logic [31:0] dat_i, dat_o, rdat;
  int          failures, n_tests;
  dpc_row_type rows [5] = '{
    '{dpc_pkg::OFS_IN1_FUNC, 5'h01, 32'h1}, '{dpc_pkg::OFS_IN2_FUNC, 5'h02, 32'h2},
    '{dpc_pkg::OFS_IN3_FUNC, 5'h04, 32'h3}, '{dpc_pkg::OFS_IN4_FUNC, 5'h08, 32'h4},
    '{dpc_pkg::OFS_FAST_FUNC, 5'h10, 32'h5}};

  dpc_pulse_src i_src (.clk_i, .rst_i, .go_i(go), .fire_i(fire), .pins_o(pins));
  dpc_counter i_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .general_input_one_i   (pins[0]),
    .general_input_two_i   (pins[1]),
    .general_input_three_i (pins[2]),
    .general_input_four_i  (pins[3]),
    .fast_pulse_input_i    (pins[4]),
    .transistor_output_o, .relay_output_first_o, .relay_output_second_o, .irq_o
  );
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; the bench never assumes the ack latency
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, rdat);
  endtask : rc
  task automatic po(input logic [3:0] e);
    chk("irq and pins", {28'h0, e}, {28'h0, irq_o, relay_output_second_o,
      relay_output_first_o, transistor_output_o});
  endtask : po
  // pin to output takes four edges; eight leaves margin past the low gap
  task automatic pulse(input logic [4:0] m);
    fire <= m;
    go   <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : pulse
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    conclude();
  end
  initial begin
    {cyc_i, stb_i, we_i, go, adr_i, fire, dat_i} <= '0;
    rst_i <= 1'b1;
    sel_i <= 4'hF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(dpc_pkg::OFS_IN1_FUNC, 32'h1);
    rc(dpc_pkg::OFS_REL2_FUNC, 32'h5);
    rc(dpc_pkg::OFS_ACCUM, 32'h0);
    rc(6'h3C, 32'h0);
    wr(dpc_pkg::OFS_FAST_TYPE, 32'h1);
    wr(dpc_pkg::OFS_SET_VALUE, 32'h100);
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i].ofs, 32'h1F);
      pulse(rows[i].pin);
      rc(dpc_pkg::OFS_ACCUM, rows[i].cnt);
      wr(rows[i].ofs, 32'h0);
    end
    done("rows");
    wr(dpc_pkg::OFS_FAST_FUNC, 32'h1F);
    wr(dpc_pkg::OFS_FAST_TYPE, 32'h0);
    pulse(5'h10);
    rc(dpc_pkg::OFS_ACCUM, 32'h5);
    wr(dpc_pkg::OFS_FAST_TYPE, 32'h1);
    wr(dpc_pkg::OFS_IN1_FUNC, 32'h1F);
    pulse(5'h11);
    rc(dpc_pkg::OFS_ACCUM, 32'h6);
    wr(dpc_pkg::OFS_ACCUM, 32'h9);
    rc(dpc_pkg::OFS_ACCUM, 32'h6);
    wr(dpc_pkg::OFS_IN2_FUNC, 32'h1C);
    pulse(5'h03);
    rc(dpc_pkg::OFS_ACCUM, 32'h0);
    done("fast and clear");
    // the row loop left input three at code 0
    wr(dpc_pkg::OFS_IN3_FUNC, 32'h60);
    rc(dpc_pkg::OFS_IN3_FUNC, 32'h0);
    sel_i <= 4'h0;
    wr(dpc_pkg::OFS_IN3_FUNC, 32'h5F);
    sel_i <= 4'hF;
    rc(dpc_pkg::OFS_IN3_FUNC, 32'h0);
    wr(dpc_pkg::OFS_IN3_FUNC, 32'h5F);
    rc(dpc_pkg::OFS_IN3_FUNC, 32'h5F);
    wr(dpc_pkg::OFS_REL2_FUNC, 32'h3F);
    rc(dpc_pkg::OFS_REL2_FUNC, 32'h3F);
    done("codes");
    wr(dpc_pkg::OFS_DESIG_VAL, 32'h2);
    wr(dpc_pkg::OFS_SET_VALUE, 32'h3);
    wr(dpc_pkg::OFS_SET_VALUE, 32'h1);
    rc(dpc_pkg::OFS_SET_VALUE, 32'h3);
    wr(dpc_pkg::OFS_TRAN_FUNC, 32'h12);
    wr(dpc_pkg::OFS_REL1_FUNC, 32'h13);
    wr(dpc_pkg::OFS_REL2_FUNC, 32'h0);
    // only the return to zero under the clear has raised an event so far
    rc(dpc_pkg::OFS_IRQ_STATUS, 32'h2);
    wr(dpc_pkg::OFS_IRQ_MASK, 32'h7);
    po(4'h0);
    pulse(5'h01);
    pulse(5'h01);
    po(4'hA);
    rc(dpc_pkg::OFS_IRQ_STATUS, 32'h2);
    po(4'h2);
    rc(dpc_pkg::OFS_PIN_STATE, 32'h200);
    pulse(5'h01);
    po(4'h9);
    rc(dpc_pkg::OFS_IRQ_STATUS, 32'h1);
    wr(dpc_pkg::OFS_IRQ_MASK, 32'h3);
    pulse(5'h01);
    po(4'h0);
    rc(dpc_pkg::OFS_IRQ_STATUS, 32'h4);
    rc(dpc_pkg::OFS_PIN_STATE, 32'h0);
    rc(dpc_pkg::OFS_ACCUM, 32'h0);
    done("count outputs");
    pulse(5'h01);
    rc(dpc_pkg::OFS_ACCUM, 32'h1);
    // reset in mid-run: three edges flush the synchroniser as well
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(dpc_pkg::OFS_ACCUM, 32'h0);
    rc(dpc_pkg::OFS_SET_VALUE, 32'h0);
    rc(dpc_pkg::OFS_IN2_FUNC, 32'h4);
    rc(dpc_pkg::OFS_TRAN_FUNC, 32'h0);
    po(4'h0);
    done("mid-run reset");
    conclude();
  end
endmodule : tb_top
